// file: pagpio_top.sv
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - an enabled peripheral takes the pin away from the port output; reads stay.
// - writes to latch register and pin level register both update the latch.
// - latch register reads latches; pin level register reads sensed pins.
// - analog select set disables that pin's digital input buffer.
// - eight-bit port; direction bit 1 makes the pin an input.
// - direction bit 0 drives the pin with its latch bit.
// - bit 3 input only; its direction bit always reads one.
// - pin level writes are read-modify-write into the latch.
// - direction bits control drivers even on analog pins.
// - digital reads of analog pins return zero.
// - analog select does not affect digital output.
// - analog select bits reset to analog.
// - analog select exists only on bits 5 and 3..0; others read zero.
// - highest priority enabled output function controls the pin.
module pagpio_top
  import pagpio_pkg::*;
#(
  parameter int WIDTH = PAGPIO_WIDTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  // peripheral functions, hi wins over lo
  input wire logic [WIDTH-1:0] periph_hi_en,
  input wire logic [WIDTH-1:0] periph_hi_out,
  input wire logic [WIDTH-1:0] periph_lo_en,
  input wire logic [WIDTH-1:0] periph_lo_out,
  // buffered digital input to peripherals
  output logic [WIDTH-1:0] digital_in
);
  logic [WIDTH-1:0] port_direction_ctrl;
  logic [WIDTH-1:0] output_latch_reg;
  logic [WIDTH-1:0] analog_select_reg;
  logic [WIDTH-1:0] periph_en_reg;
  logic [WIDTH-1:0] pin_sync;
  logic [WIDTH-1:0] mux_oe;
  logic [WIDTH-1:0] mux_val;

  pagpio_sync #(.WIDTH(WIDTH)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // per-pin driver resolution
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      pagpio_pin_mux u_mux (
        .port_drive_en(~port_direction_ctrl[gi]),
        .port_value(output_latch_reg[gi]),
        .periph_hi_en(periph_hi_en[gi] & periph_en_reg[gi]),
        .periph_hi_out(periph_hi_out[gi]),
        .periph_lo_en(periph_lo_en[gi] & periph_en_reg[gi]),
        .periph_lo_out(periph_lo_out[gi]),
        .pin_oe(mux_oe[gi]),
        .pin_val(mux_val[gi])
      );
    end
  endgenerate

  // apb decode
  wire setup_or_access = psel & penable;
  // a pin level write always lands; other registers need byte lane 0
  wire wr_access = setup_or_access & pwrite;
  wire wr_fire = wr_access & pstrb[0];
  wire hit_pin = paddr == PAGPIO_OFF_PIN_LEVEL;
  wire hit_dir = paddr == PAGPIO_OFF_DIRECTION;
  wire hit_lat = paddr == PAGPIO_OFF_LATCH;
  wire hit_ana = paddr == PAGPIO_OFF_ANALOG;
  wire hit_pen = paddr == PAGPIO_OFF_PERIPH_EN;
  wire hit_any = hit_pin | hit_dir | hit_lat | hit_ana | hit_pen;
  wire [WIDTH-1:0] wdata = pwdata[WIDTH-1:0];

  // input buffer gated by analog select
  wire [WIDTH-1:0] sensed = pin_sync & ~analog_select_reg;
  // read-modify-write: unwritten byte lanes keep the sensed level
  wire [WIDTH-1:0] rmw_value = pstrb[0] ? wdata : sensed;
  wire [WIDTH-1:0] dir_read = port_direction_ctrl | PAGPIO_INPUT_ONLY_MASK;
  wire [WIDTH-1:0] rd_byte =
    hit_pin ? sensed :
    hit_dir ? dir_read :
    hit_lat ? output_latch_reg :
    hit_ana ? (analog_select_reg & PAGPIO_ANALOG_IMPL_MASK) :
    hit_pen ? periph_en_reg : '0;
  wire lat_load = (hit_pin & wr_access) | (hit_lat & wr_fire);
  wire [WIDTH-1:0] lat_src = hit_pin ? rmw_value : wdata;
  wire [WIDTH-1:0] next_latch = lat_load ? lat_src : output_latch_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_direction_ctrl <= PAGPIO_DIRECTION_RST;
      output_latch_reg <= PAGPIO_LATCH_RST;
      analog_select_reg <= PAGPIO_ANALOG_RST;
      periph_en_reg <= PAGPIO_PERIPH_EN_RST;
    end else begin
      output_latch_reg <= next_latch;
      if (wr_fire && hit_dir) begin
        port_direction_ctrl <= wdata | PAGPIO_INPUT_ONLY_MASK;
      end
      if (wr_fire && hit_ana) begin
        analog_select_reg <= wdata & PAGPIO_ANALOG_IMPL_MASK;
      end
      if (wr_fire && hit_pen) begin
        periph_en_reg <= wdata;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
      digital_in <= '0;
    end else begin
      pin_oe <= mux_oe & ~PAGPIO_INPUT_ONLY_MASK;
      pin_out <= mux_val;
      digital_in <= sensed;
    end
  end

  AST_DIR3_ONE: assert property (@(posedge mclk) disable iff (rst)
    port_direction_ctrl[PAGPIO_INPUT_ONLY_POS]) else $error("bit 3 direction not one");
  AST_ANA_UNIMPL: assert property (@(posedge mclk) disable iff (rst)
    (analog_select_reg & ~PAGPIO_ANALOG_IMPL_MASK) == '0) else $error("bad analog bit");
  AST_LAT_WRITE: assert property (@(posedge mclk) disable iff (rst)
    (wr_fire && hit_lat) |=> output_latch_reg == $past(wdata))
    else $error("latch write lost");
  AST_PIN_WRITE: assert property (@(posedge mclk) disable iff (rst)
    (wr_fire && hit_pin) |=> output_latch_reg == $past(wdata))
    else $error("pin level write lost");
  AST_DRIVE: assert property (@(posedge mclk) disable iff (rst)
    ##1 (pin_oe == ($past(mux_oe) & ~PAGPIO_INPUT_ONLY_MASK)))
    else $error("drive enable mismatch");
  AST_INPUT_TRI: assert property (@(posedge mclk) disable iff (rst)
    (port_direction_ctrl[0] && !periph_hi_en[0] && !periph_lo_en[0]) |=> !pin_oe[0])
    else $error("input pin driven");
  AST_PERIPH_WINS: assert property (@(posedge mclk) disable iff (rst)
    (periph_en_reg[0] && periph_hi_en[0]) |=> pin_out[0] == $past(periph_hi_out[0]))
    else $error("priority wrong");
  AST_ANALOG_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (analog_select_reg[0]) |-> !sensed[0]) else $error("analog pin reads one");
  AST_ANALOG_DRIVES: assert property (@(posedge mclk) disable iff (rst)
    (analog_select_reg[1] && !port_direction_ctrl[1] && !periph_en_reg[1]) |=>
    (pin_oe[1] && pin_out[1] == $past(output_latch_reg[1])))
    else $error("analog pin not driving");
  AST_APB_ONE_WAIT: assert property (@(posedge mclk) disable iff (rst)
    (psel && !penable) |=> pready) else $error("pready late");

  COV_WRITE_LAT: cover property (@(posedge mclk) disable iff (rst) wr_fire && hit_lat);
  COV_READ_PIN: cover property (@(posedge mclk) disable iff (rst)
    setup_or_access && !pwrite && hit_pin);
  COV_PERIPH: cover property (@(posedge mclk) disable iff (rst) |(mux_oe & periph_en_reg));
  COV_UNMAPPED: cover property (@(posedge mclk) disable iff (rst) pslverr && pready);
endmodule

// file: pagpio_pkg.sv
package pagpio_pkg;
  localparam int PAGPIO_WIDTH = 8;
  // register byte addresses on apb
  localparam logic [11:0] PAGPIO_OFF_PIN_LEVEL = 12'h000;
  localparam logic [11:0] PAGPIO_OFF_DIRECTION = 12'h004;
  localparam logic [11:0] PAGPIO_OFF_LATCH = 12'h008;
  localparam logic [11:0] PAGPIO_OFF_ANALOG = 12'h00c;
  localparam logic [11:0] PAGPIO_OFF_PERIPH_EN = 12'h010;
  // field positions and masks
  localparam int PAGPIO_INPUT_ONLY_POS = 3;
  localparam logic [7:0] PAGPIO_INPUT_ONLY_MASK = 8'h08;
  localparam logic [7:0] PAGPIO_ANALOG_IMPL_MASK = 8'h2f;
  // reset values
  localparam logic [7:0] PAGPIO_DIRECTION_RST = 8'hff;
  localparam logic [7:0] PAGPIO_LATCH_RST = 8'h00;
  localparam logic [7:0] PAGPIO_ANALOG_RST = 8'h2f;
  localparam logic [7:0] PAGPIO_PERIPH_EN_RST = 8'h00;
  // synchroniser depth
  localparam int PAGPIO_SYNC_STAGES = 2;
endpackage

// file: pagpio_sync.sv
`timescale 1ns/1ps
module pagpio_sync
  import pagpio_pkg::*;
#(
  parameter int WIDTH = PAGPIO_WIDTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// file: pagpio_pin_mux.sv
`timescale 1ns/1ps
module pagpio_pin_mux (
  // port side
  input wire logic port_drive_en,
  input wire logic port_value,
  // two peripheral functions, periph_hi wins
  input wire logic periph_hi_en,
  input wire logic periph_hi_out,
  input wire logic periph_lo_en,
  input wire logic periph_lo_out,
  // resolved pin drive
  output logic pin_oe,
  output logic pin_val
);
  wire any_periph = periph_hi_en | periph_lo_en;
  wire periph_val = periph_hi_en ? periph_hi_out : periph_lo_out;

  assign pin_oe = any_periph | port_drive_en;
  assign pin_val = any_periph ? periph_val : port_value;
endmodule

// file: pagpio_pins.sv
`timescale 1ns/1ps
module pagpio_pins (
  // device drive
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // outside drivers
  input wire logic [7:0] ext_val,
  // sensed levels
  output logic [7:0] pin_in
);
  // device wins where it drives, outside level elsewhere
  assign pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pagpio_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, er;
  logic [7:0] pin_in, pin_out, pin_oe, digital_in, ext_val = 8'h00;
  logic [7:0] hi_en = 8'h00, hi_out = 8'h00, lo_en = 8'h00, lo_out = 8'h00;
  logic [7:0] d, rd;
  logic [11:0] ra[4] = '{PAGPIO_OFF_DIRECTION, PAGPIO_OFF_LATCH, PAGPIO_OFF_ANALOG,
    PAGPIO_OFF_PERIPH_EN};
  logic [7:0] rv[4] = '{8'hff, 8'h00, 8'h2f, 8'h00};
  int err_count = 0, num_checks = 0, cyc = 0;
  int m_dir, m_lat, m_ana, m_pen, pe, oe, val, ex;
  always #4 mclk = ~mclk;
  pagpio_top pagpio_top_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .periph_hi_en(hi_en), .periph_hi_out(hi_out),
    .periph_lo_en(lo_en), .periph_lo_out(lo_out), .digital_in(digital_in));
  pagpio_pins pagpio_pins_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .pin_in(pin_in));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] dv,
      input logic s);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, dv};
    pstrb <= {4{s}};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", pready, 1);
    rd = prdata[7:0];
    er = pslverr;
    if (!w) chk("prdata_hi", prdata[31:8], 0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected drive and sensed levels
  task automatic model();
    pe = m_pen & (hi_en | lo_en);
    oe = (pe | ~m_dir) & 'hf7;
    val = (m_pen & hi_en & hi_out) | (m_pen & ~hi_en & lo_en & lo_out) | (~pe & m_lat);
    ex = ((val & oe) | (ext_val & ~oe)) & ~m_ana & 'hff;
  endtask
  initial begin
    void'($urandom(32'h4124));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    m_dir = 'hff;
    m_lat = 0;
    m_ana = 'h2f;
    m_pen = 0;
    for (int i = 0; i < 4; i++) begin
      apb(0, ra[i], 0, 1);
      chk("reset_value", rd, rv[i]);
    end
    apb(0, 12'h020, 0, 1);
    chk("unmapped_err", {er, rd}, 9'h100);
    $display("test reset done");
    for (int k = 0; k < 40; k++) begin
      d = $urandom;
      m_dir = d | 8'h08;
      apb(1, PAGPIO_OFF_DIRECTION, d, 1);
      d = $urandom;
      m_ana = d & 8'h2f;
      apb(1, PAGPIO_OFF_ANALOG, d, 1);
      d = $urandom;
      m_pen = (k < 10) ? 0 : d;
      apb(1, PAGPIO_OFF_PERIPH_EN, m_pen[7:0], 1);
      d = $urandom;
      m_lat = d;
      apb(1, k[0] ? PAGPIO_OFF_LATCH : PAGPIO_OFF_PIN_LEVEL, d, 1);
      hi_en <= $urandom;
      hi_out <= $urandom;
      lo_en <= $urandom;
      lo_out <= $urandom;
      ext_val <= $urandom;
      repeat (5) @(posedge mclk);
      model();
      chk("pin_oe", pin_oe, oe[7:0]);
      chk("pin_out", pin_out & pin_oe, val & oe);
      chk("digital_in", digital_in, ex[7:0]);
      apb(0, PAGPIO_OFF_DIRECTION, 0, 1);
      chk("dir", rd, m_dir[7:0]);
      apb(0, PAGPIO_OFF_ANALOG, 0, 1);
      chk("analog", rd, m_ana[7:0]);
      apb(0, PAGPIO_OFF_PIN_LEVEL, 0, 1);
      chk("pin_level", rd, ex[7:0]);
      if (k[1]) begin
        apb(1, PAGPIO_OFF_PIN_LEVEL, $urandom, 0);
        m_lat = ex;
      end
      apb(0, PAGPIO_OFF_LATCH, 0, 1);
      chk("latch", rd, m_lat[7:0]);
    end
    $display("test random done");
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    apb(0, PAGPIO_OFF_ANALOG, 0, 1);
    chk("analog_rerst", rd, 8'h2f);
    $display("test rereset done");
    report_and_stop();
  end
endmodule
